// ==== sim/tb_top.sv ====
// Purpose: Self-checking bench
// Assumes: Converter model on the far side
// Notes: Freeze window shortened to keep the run brief
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import tcs_pkg::*;
;
    localparam int HOLD = 200;
    logic CLK_SYS = 1'b0;
    logic SYS_RST = 1'b1;
    logic PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
    logic [7:0] PADDR = 8'h00;
    logic [31:0] PWDATA = 32'h0, PRDATA, q;
    logic PREADY, PSLVERR, ADC_DONE, ADC_START, RES_CANCEL_EN, OVER_TEMP_O, OVER_TEMP_OE, IRQ, e;
    logic [15:0] ADC_RESULT;
    logic [1:0] ADC_CHANNEL;
    logic [2:0] DIODE_FAULT = 3'h0, ADDR_SELECT = 3'h5;
    logic [6:0] BUS_TARGET_ADDR;
    logic slow = 1'b0;
    logic [63:0] temps = 64'h2d43_2c42_2b41_2a40;
    int n_mismatch = 0, check_count = 0, cyc = 0;
    int done_cnt [4] = '{0, 0, 0, 0};
    logic [1:0] log_q [$];
    // Free-running clock
    always #10 CLK_SYS = ~CLK_SYS;
    tcs_top #(.HOLD_CYC(HOLD)) uut (.*);
    tcs_adc_model u_adc (.clk(CLK_SYS), .rst(SYS_RST), .start(ADC_START), .chan(ADC_CHANNEL), .slow(slow),
        .temps(temps), .done(ADC_DONE), .result(ADC_RESULT));
    // Start log, done counts and hang guard
    always @(posedge CLK_SYS)
    begin
        cyc = cyc + 1;
        if (ADC_START === 1'b1)
            log_q.push_back(ADC_CHANNEL);
        if (ADC_DONE === 1'b1)
            done_cnt[ADC_CHANNEL] = done_cnt[ADC_CHANNEL] + 1;
        if (cyc == 60000)
        begin
            n_mismatch = n_mismatch + 1;
            close_out();
        end
    end
    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : close_out
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        check_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("ERROR %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask : chk
    // One APB transfer
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge CLK_SYS);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLK_SYS);
        PENABLE <= 1'b1;
        do
            @(posedge CLK_SYS);
        while (PREADY !== 1'b1 && ++n < 20);
        if (n >= 20)
            chk(32'h0, 32'h1, "no ready");
        q = PRDATA;
        e = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask : apb
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string msg);
        apb(1'b0, a, 32'h0);
        chk(q, exp, msg);
    endtask : rdc
    task automatic wait_done(input int ch, input int k);
        int t;
        t = done_cnt[ch] + k;
        while (done_cnt[ch] < t)
            @(posedge CLK_SYS);
        repeat (6) @(posedge CLK_SYS);
    endtask : wait_done
    task automatic wait_starts(input int k);
        int t;
        t = log_q.size() + k;
        while (log_q.size() < t)
            @(posedge CLK_SYS);
    endtask : wait_starts
    function automatic logic [1:0] nxt(input logic [1:0] c, input logic [3:0] m);
        logic [1:0] r;
        int j;
        r = c;
        for (int k = 4; k >= 1; k--)
        begin
            j = (c + k) % 4;
            if (m[j])
                r = 2'(j);
        end
        return r;
    endfunction : nxt
    task automatic check_order(input logic [3:0] m);
        wait_starts(6);
        log_q.delete();
        wait_starts(9);
        for (int i = 0; i < 8; i++)
            chk({30'h0, log_q[i + 1]}, {30'h0, nxt(log_q[i], m)}, "conversion order");
    endtask : check_order
    task automatic t_reset();
        chk({25'h0, BUS_TARGET_ADDR}, {25'h0, BUS_ADDR_BASE, 3'h5}, "target address");
        ADDR_SELECT <= 3'h2;
        rdc(OFS_CONFIG, {29'h0, CONFIG_RST}, "config reset");
        rdc(OFS_CHAN_EN, {28'h0, CHAN_EN_RST}, "enable reset");
        rdc(OFS_THRESH, {16'h0, THRESH_RST}, "threshold reset");
        rdc(OFS_INT_MASK, 32'h0, "mask reset");
        rdc(OFS_BUS_ADDR, {25'h0, BUS_ADDR_BASE, 3'h5}, "address register");
        apb(1'b0, 8'h50, 32'h0);
        chk({31'h0, e}, 32'h1, "unmapped error");
        chk({25'h0, BUS_TARGET_ADDR}, {25'h0, BUS_ADDR_BASE, 3'h5}, "address resampled");
        chk({31'h0, RES_CANCEL_EN}, 32'h1, "compensation off");
    endtask : t_reset
    task automatic t_order();
        check_order(4'hf);
        for (int i = 0; i < 4; i++)
        begin
            rdc(OFS_TEMP_HI + TEMP_STRIDE * 8'(i), {24'h0, temps[16 * i + 8 +: 8]}, "stored hi");
            rdc(OFS_TEMP_LO + TEMP_STRIDE * 8'(i), {24'h0, temps[16 * i +: 8]}, "stored lo");
        end
    endtask : t_order
    task automatic t_skip();
        DIODE_FAULT <= 3'b010;
        apb(1'b1, OFS_CHAN_EN, 32'h7);
        check_order(4'b0101);
        DIODE_FAULT <= 3'b000;
        apb(1'b1, OFS_CHAN_EN, 32'hf);
    endtask : t_skip
    task automatic t_standby();
        int n;
        slow <= 1'b1;
        temps[63:48] <= 16'h3e10;
        wait_starts(5);
        while (log_q[$] != 2'h1)
            @(posedge CLK_SYS);
        apb(1'b1, OFS_CONFIG, 32'h5);
        wait_done(3, 1);
        n = log_q.size();
        repeat (60) @(posedge CLK_SYS);
        chk(log_q.size(), n, "start in standby");
        chk({30'h0, log_q[$]}, 32'h3, "sequence cut short");
        rdc(OFS_TEMP_HI + 8'h18, 32'h3e, "local stored");
        apb(1'b1, OFS_THRESH + 8'h08, 32'h4400);
        rdc(OFS_THRESH + 8'h08, 32'h4400, "bus in standby");
        rdc(OFS_CONFIG, 32'h5, "config kept");
        apb(1'b1, OFS_CONFIG, 32'h4);
        wait_starts(1);
        chk({30'h0, log_q[$]}, 32'h0, "restart channel");
        slow <= 1'b0;
    endtask : t_standby
    task automatic t_over();
        temps[31:16] <= 16'h6010;
        wait_done(1, 1);
        chk({31'h0, OVER_TEMP_OE}, 32'h1, "pin not asserted");
        apb(1'b1, OFS_CONFIG, 32'h0);
        repeat (4) @(posedge CLK_SYS);
        chk({31'h0, OVER_TEMP_OE}, 32'h0, "pin while disabled");
        apb(1'b1, OFS_CONFIG, 32'h6);
        repeat (4) @(posedge CLK_SYS);
        chk({31'h0, OVER_TEMP_OE}, 32'h1, "alert pin");
        apb(1'b0, OFS_INT_STATUS, 32'h0);
        chk(q & 32'hf, 32'h2, "over event");
        apb(1'b1, OFS_INT_STATUS, 32'h1f);
        repeat (4) @(posedge CLK_SYS);
        chk({31'h0, OVER_TEMP_OE}, 32'h0, "alert not cleared");
        apb(1'b1, OFS_INT_MASK, 32'h10);
        wait_done(3, 1);
        chk({31'h0, IRQ}, 32'h1, "irq missing");
        apb(1'b1, OFS_INT_MASK, 32'h0);
        repeat (4) @(posedge CLK_SYS);
        chk({31'h0, IRQ}, 32'h0, "irq while masked");
        temps[31:16] <= 16'h2b41;
        apb(1'b1, OFS_INT_STATUS, 32'h1f);
        apb(1'b1, OFS_CONFIG, 32'h4);
    endtask : t_over
    task automatic t_freeze();
        temps[15:0] <= 16'h3344;
        wait_done(0, 1);
        rdc(OFS_TEMP_HI, 32'h33, "hi byte");
        temps[15:0] <= 16'h3577;
        wait_done(0, 1);
        rdc(OFS_TEMP_LO, 32'h44, "lo not held");
        rdc(OFS_TEMP_LO, 32'h77, "lo not released");
        rdc(OFS_TEMP_HI, 32'h35, "hi byte new");
        temps[15:0] <= 16'h3699;
        repeat (HOLD + 60) @(posedge CLK_SYS);
        rdc(OFS_TEMP_LO, 32'h99, "hold not expired");
    endtask : t_freeze
    // Main sequence
    initial
    begin
        repeat (6) @(posedge CLK_SYS);
        SYS_RST <= 1'b0;
        repeat (2) @(posedge CLK_SYS);
        t_reset();
        t_order();
        t_skip();
        t_standby();
        t_over();
        t_freeze();
        close_out();
    end
endmodule : tb_top
bind tcs_top tcs_top_chk u_chk (.*);
`default_nettype wire

// ==== sim/tcs_adc_model.sv ====
// Purpose: Converter model, one done pulse per start
// Assumes: Start is a one-cycle pulse with the channel valid beside it
// Notes: Result lines toggle outside the done cycle
`timescale 1ns/1ps
`default_nettype none
module tcs_adc_model
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Request side
    input wire logic start,
    input wire logic [1:0] chan,
    input wire logic slow,
    input wire logic [63:0] temps,
    // Answer side
    output logic done,
    output logic [15:0] result
);
    int cnt;
    logic [1:0] ch_q;
    // Count down, then answer once
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cnt <= 0;
            ch_q <= 2'h0;
            done <= 1'b0;
            result <= 16'h0;
        end
        else
        begin
            done <= 1'b0;
            result <= ~result;
            if (start)
            begin
                cnt <= slow ? 12 : 3;
                ch_q <= chan;
            end
            else if (cnt == 1)
            begin
                done <= 1'b1;
                result <= temps[16 * ch_q +: 16];
                cnt <= 0;
            end
            else if (cnt > 1)
                cnt <= cnt - 1;
        end
    end
endmodule : tcs_adc_model
`default_nettype wire

// ==== sim/tcs_top_chk.sv ====
// Purpose: Port-level assertions
// Assumes: APB writes land at the ready edge
// Notes: Config and mask copies track observed writes
`timescale 1ns/1ps
`default_nettype none
module tcs_top_chk
    import tcs_pkg::*;
(
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic SYS_RST,
    // APB
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    // Converter
    input wire logic ADC_DONE,
    input wire logic ADC_START,
    input wire logic [1:0] ADC_CHANNEL,
    input wire logic RES_CANCEL_EN,
    // Straps, pin and interrupt
    input wire logic [6:0] BUS_TARGET_ADDR,
    input wire logic OVER_TEMP_O,
    input wire logic OVER_TEMP_OE,
    input wire logic IRQ
);
    logic [2:0] cfg;
    logic [4:0] mask;
    logic in_conv;
    logic stop;
    logic [1:0] post;
    logic wr_ok;
    logic mapped;
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (SYS_RST);
    // Completed writes and address map
    assign wr_ok = PSEL && PENABLE && PREADY && PWRITE && !PSLVERR;
    assign mapped = (PADDR[1:0] == 2'h0) && (PADDR <= 8'h3c || PADDR == OFS_INT_STATUS || PADDR == OFS_INT_MASK);
    // Configuration and mask copies
    always_ff @(posedge CLK_SYS or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            cfg <= CONFIG_RST;
            mask <= INT_MASK_RST;
        end
        else if (wr_ok && PADDR == OFS_CONFIG)
            cfg <= PWDATA[2:0];
        else if (wr_ok && PADDR == OFS_INT_MASK)
            mask <= PWDATA[4:0];
    end
    // Conversion window, standby stop, age
    always_ff @(posedge CLK_SYS or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            in_conv <= 1'b0;
            stop <= 1'b0;
            post <= 2'h0;
        end
        else
        begin
            in_conv <= ADC_START || (in_conv && !ADC_DONE);
            stop <= cfg[CFG_STANDBY] && (stop || (in_conv && ADC_DONE && ADC_CHANNEL == 2'h3));
            post <= post + {1'b0, post != 2'h2};
        end
    end
    AST_RES_CANCEL: assert property (RES_CANCEL_EN)
        else $error("compensation enable dropped");
    AST_ADDR_HOLD: assert property (post == 2'h2 |-> $stable(BUS_TARGET_ADDR) && BUS_TARGET_ADDR[6:3] == BUS_ADDR_BASE)
        else $error("target address changed after load");
    AST_OD_LEVEL: assert property (OVER_TEMP_O == 1'b0)
        else $error("open-drain pin driven high");
    AST_CMP_GATE: assert property ((!cfg[CFG_OUT_EN] && !cfg[CFG_INT_MODE]) [*4] |-> !OVER_TEMP_OE)
        else $error("pin asserted while output disabled");
    AST_CHAN_STABLE: assert property (in_conv |=> $stable(ADC_CHANNEL))
        else $error("channel moved during conversion");
    AST_ONE_CONV: assert property (in_conv |-> !ADC_START)
        else $error("start during a running conversion");
    AST_STANDBY_STOP: assert property (stop |-> !ADC_START)
        else $error("conversion started in standby");
    AST_APB_WAIT: assert property (PSEL && PENABLE && !PREADY |=> PREADY ##1 !PREADY)
        else $error("ready not one wait state");
    AST_APB_ERR: assert property (PREADY |-> PSLVERR == !mapped)
        else $error("error flag wrong for address");
    AST_IRQ_MASK: assert property ((mask == 5'h0) [*3] |-> !IRQ)
        else $error("interrupt with all sources masked");
    // Main scenarios reached
    COV_STOP: cover property (stop && !ADC_START);
    COV_LOCAL: cover property (in_conv && ADC_DONE && ADC_CHANNEL == 2'h3);
    COV_PIN: cover property ($rose(OVER_TEMP_OE));
    COV_ERR: cover property (PREADY && PSLVERR);
endmodule : tcs_top_chk
`default_nettype wire

// ==== src/tcs_freeze.sv ====
// Purpose: Holds the second byte of a temperature value
// Assumes: Reads arrive as one-cycle strobes
// Notes: The hold is dropped on the second-byte read or after the window
`timescale 1ns/1ps
`default_nettype none
module tcs_freeze
    import tcs_pkg::*;
#(
    parameter int HOLD_CYC = FREEZE_CYC
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Live value and read strobes
    input wire logic [15:0] live,
    input wire logic rd_hi,
    input wire logic rd_lo,
    // Low byte as software sees it
    output logic [7:0] lo_byte,
    output logic frozen
);
    logic [31:0] hold_cnt;

    // Freeze on first-byte read, release on second-byte read or timeout
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            frozen <= 1'b0;
            hold_cnt <= '0;
        end
        else if (rd_hi)
        begin
            frozen <= 1'b1;
            hold_cnt <= 32'(HOLD_CYC);
        end
        else if (rd_lo || (frozen && hold_cnt <= 32'd1))
        begin
            frozen <= 1'b0;
        end
        else if (frozen)
        begin
            hold_cnt <= hold_cnt - 32'd1;
        end
    end

    // Shadow low byte follows the live value unless held
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            lo_byte <= '0;
        end
        else if (rd_hi || !frozen)
        begin
            lo_byte <= live[7:0];
        end
    end
endmodule : tcs_freeze
`default_nettype wire

// ==== src/tcs_pkg.sv ====
// Purpose: Shared constants for the temperature conversion sequencer
// Assumes: APB register bus, 32-bit data, byte addresses
// Notes: Channel 0..2 are remote diodes 1..3, channel 3 is local
package tcs_pkg;
    // Geometry
    localparam int NUM_CH = 4;
    localparam int NUM_REMOTE = 3;
    localparam int TEMP_W = 16;
    localparam int ADDR_W = 8;

    // Register byte offsets
    localparam logic [7:0] OFS_CONFIG = 8'h00;
    localparam logic [7:0] OFS_CHAN_EN = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_BUS_ADDR = 8'h0c;
    localparam logic [7:0] OFS_TEMP_HI = 8'h10;
    localparam logic [7:0] OFS_TEMP_LO = 8'h14;
    localparam logic [7:0] TEMP_STRIDE = 8'h08;
    localparam logic [7:0] OFS_THRESH = 8'h30;
    localparam logic [7:0] OFS_INT_STATUS = 8'h40;
    localparam logic [7:0] OFS_INT_MASK = 8'h44;

    // Configuration fields
    localparam int CFG_STANDBY = 0;
    localparam int CFG_INT_MODE = 1;
    localparam int CFG_OUT_EN = 2;

    // Interrupt status fields
    localparam int IRQ_SEQ_DONE = 4;
    localparam int IRQ_W = 5;

    // Reset values
    localparam logic [2:0] CONFIG_RST = 3'h4;
    localparam logic [3:0] CHAN_EN_RST = 4'hf;
    localparam logic [15:0] THRESH_RST = 16'h5500;
    localparam logic [4:0] INT_MASK_RST = 5'h00;

    // Bus address base, arbitrary value; strap adds low bits
    localparam logic [3:0] BUS_ADDR_BASE = 4'h9;

    // Second-byte freeze window
    localparam int FREEZE_MS = 35;
    localparam int CLK_HZ = 50_000_000;
    localparam int FREEZE_CYC = FREEZE_MS * (CLK_HZ / 1000);

    // Sequencer states
    typedef enum logic [2:0] {
        TCS_IDLE = 3'b000,
        TCS_PICK = 3'b001,
        TCS_START = 3'b010,
        TCS_WAIT = 3'b011,
        TCS_NEXT = 3'b100
    } tcs_state_e;
endpackage : tcs_pkg

// ==== src/tcs_seq.sv ====
// Purpose: Walks the four channels in order and runs one conversion on each enabled channel without a diode fault
// Assumes: Converter answers each start with one done pulse and a result
// Notes: Standby is looked at only between sequences
`timescale 1ns/1ps
`default_nettype none
module tcs_seq
    import tcs_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Control
    input wire logic standby,
    input wire logic [3:0] chan_en,
    input wire logic [2:0] diode_fault,
    // Converter
    input wire logic adc_done,
    input wire logic [15:0] adc_result,
    output logic adc_start,
    output logic [1:0] adc_chan,
    // Result write
    output logic wr_en,
    output logic [15:0] wr_data,
    output logic seq_done,
    output logic busy
);
    tcs_state_e state;
    logic skip;

    // Faulty remote diode or disabled channel is not converted
    always_comb
    begin
        skip = !chan_en[adc_chan];
        if (adc_chan != 2'd3 && diode_fault[adc_chan])
        begin
            skip = 1'b1;
        end
    end

    // Channel sequencing
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state <= TCS_IDLE;
            adc_chan <= '0;
            adc_start <= 1'b0;
            wr_en <= 1'b0;
            wr_data <= '0;
            seq_done <= 1'b0;
            busy <= 1'b0;
        end
        else
        begin
            adc_start <= 1'b0;
            wr_en <= 1'b0;
            seq_done <= 1'b0;
            case (state)
                TCS_IDLE:
                begin
                    adc_chan <= 2'd0;
                    busy <= 1'b0;
                    if (!standby)
                    begin
                        busy <= 1'b1;
                        state <= TCS_PICK;
                    end
                end
                TCS_PICK:
                begin
                    state <= skip ? TCS_NEXT : TCS_START;
                end
                TCS_START:
                begin
                    adc_start <= 1'b1;
                    state <= TCS_WAIT;
                end
                TCS_WAIT:
                begin
                    if (adc_done)
                    begin
                        wr_en <= 1'b1;
                        wr_data <= adc_result;
                        state <= TCS_NEXT;
                    end
                end
                TCS_NEXT:
                begin
                    if (adc_chan == 2'd3)
                    begin
                        seq_done <= 1'b1;
                        state <= TCS_IDLE;
                    end
                    else
                    begin
                        adc_chan <= adc_chan + 2'd1;
                        state <= TCS_PICK;
                    end
                end
                default:
                begin
                    state <= TCS_IDLE;
                end
            endcase
        end
    end
endmodule : tcs_seq
`default_nettype wire

// ==== src/tcs_top.sv ====
// Purpose: Four-channel temperature conversion sequencer with APB registers
// Assumes: Converter and diode fault detector are outside this block
// Notes: Open-drain pin, driven low through its enable
`timescale 1ns/1ps
`default_nettype none
module tcs_top
    import tcs_pkg::*;
#(
    parameter int HOLD_CYC = FREEZE_CYC
)
(
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic SYS_RST,
    // APB slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Converter
    input wire logic ADC_DONE,
    input wire logic [15:0] ADC_RESULT,
    output logic ADC_START,
    output logic [1:0] ADC_CHANNEL,
    output logic RES_CANCEL_EN,
    // Remote diode fault flags, one per remote channel
    input wire logic [2:0] DIODE_FAULT,
    // Address strap and chosen serial target address
    input wire logic [2:0] ADDR_SELECT,
    output logic [6:0] BUS_TARGET_ADDR,
    // Over-temperature pin, open-drain
    output logic OVER_TEMP_O,
    output logic OVER_TEMP_OE,
    // Interrupt
    output logic IRQ
);
    // Register state
    logic [2:0] config_reg;
    logic [3:0] chan_en;
    logic [15:0] temp [NUM_CH];
    logic [15:0] thresh [NUM_CH];
    logic [3:0] temp_valid;
    logic [IRQ_W-1:0] int_status;
    logic [IRQ_W-1:0] int_mask;
    logic [3:0] over;
    logic [3:0] over_d;
    logic strap_done;
    logic [7:0] lo_byte [NUM_CH];
    logic [3:0] frozen;
    logic [3:0] rd_hi;
    logic [3:0] rd_lo;

    // Strobes and internal links
    logic seq_wr_en;
    logic [15:0] seq_wr_data;
    logic seq_done;
    logic seq_busy;
    logic apb_done;
    logic apb_wr;
    logic apb_rd;
    logic [31:0] next_rdata;
    logic next_err;
    logic [IRQ_W-1:0] int_set;

    // Transfer completes on the edge where the slave shows ready
    assign apb_done = PSEL && PENABLE && PREADY;
    assign apb_wr = apb_done && PWRITE;
    assign apb_rd = apb_done && !PWRITE;

    // Event vector: sequence end above per-channel over entry
    assign int_set = {seq_done, over & ~over_d};

    // Channel sequencer
    tcs_seq u_seq (
        .clk(CLK_SYS),
        .rst(SYS_RST),
        .standby(config_reg[CFG_STANDBY]),
        .chan_en(chan_en),
        .diode_fault(DIODE_FAULT),
        .adc_done(ADC_DONE),
        .adc_result(ADC_RESULT),
        .adc_start(ADC_START),
        .adc_chan(ADC_CHANNEL),
        .wr_en(seq_wr_en),
        .wr_data(seq_wr_data),
        .seq_done(seq_done),
        .busy(seq_busy)
    );

    // Per-channel result storage, second-byte hold and threshold check
    generate
        for (genvar c = 0; c < NUM_CH; c++)
        begin : g_ch
            always_ff @(posedge CLK_SYS or posedge SYS_RST)
            begin
                if (SYS_RST)
                begin
                    temp[c] <= '0;
                    temp_valid[c] <= 1'b0;
                end
                else if (seq_wr_en && ADC_CHANNEL == 2'(c))
                begin
                    temp[c] <= seq_wr_data;
                    temp_valid[c] <= 1'b1;
                end
            end

            always_ff @(posedge CLK_SYS or posedge SYS_RST)
            begin
                if (SYS_RST)
                begin
                    thresh[c] <= THRESH_RST;
                end
                else if (apb_wr && PADDR == OFS_THRESH + 8'(4 * c))
                begin
                    thresh[c] <= PWDATA[15:0];
                end
            end

            assign rd_hi[c] = apb_rd && PADDR == OFS_TEMP_HI + 8'(8 * c);
            assign rd_lo[c] = apb_rd && PADDR == OFS_TEMP_LO + 8'(8 * c);
            assign over[c] = temp_valid[c] && chan_en[c] && ($signed(temp[c]) > $signed(thresh[c]));

            tcs_freeze #(
                .HOLD_CYC(HOLD_CYC)
            ) u_freeze (
                .clk(CLK_SYS),
                .rst(SYS_RST),
                .live(temp[c]),
                .rd_hi(rd_hi[c]),
                .rd_lo(rd_lo[c]),
                .lo_byte(lo_byte[c]),
                .frozen(frozen[c])
            );
        end
    endgenerate

    // Configuration and channel enable registers
    always_ff @(posedge CLK_SYS or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            config_reg <= CONFIG_RST;
            chan_en <= CHAN_EN_RST;
        end
        else if (apb_wr && PADDR == OFS_CONFIG)
        begin
            config_reg <= PWDATA[2:0];
        end
        else if (apb_wr && PADDR == OFS_CHAN_EN)
        begin
            chan_en <= PWDATA[3:0];
        end
    end

    // Compensation has no control bit and stays on
    always_ff @(posedge CLK_SYS or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            RES_CANCEL_EN <= 1'b1;
        end
        else
        begin
            RES_CANCEL_EN <= 1'b1;
        end
    end

    // Strap caught once, the first edge after reset release
    always_ff @(posedge CLK_SYS or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            strap_done <= 1'b0;
            BUS_TARGET_ADDR <= '0;
        end
        else if (!strap_done)
        begin
            strap_done <= 1'b1;
            BUS_TARGET_ADDR <= {BUS_ADDR_BASE, ADDR_SELECT};
        end
    end

    // Sticky events: over-temperature entry per channel and sequence end
    always_ff @(posedge CLK_SYS or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            over_d <= '0;
            int_status <= '0;
        end
        else
        begin
            over_d <= over;
            // Set beats a same-cycle write-one clear
            for (int i = 0; i < IRQ_W; i++)
            begin
                if (int_set[i])
                begin
                    int_status[i] <= 1'b1;
                end
                else if (apb_wr && PADDR == OFS_INT_STATUS && PWDATA[i])
                begin
                    int_status[i] <= 1'b0;
                end
            end
        end
    end

    // Interrupt mask
    always_ff @(posedge CLK_SYS or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            int_mask <= INT_MASK_RST;
        end
        else if (apb_wr && PADDR == OFS_INT_MASK)
        begin
            int_mask <= PWDATA[IRQ_W-1:0];
        end
    end

    // Level interrupt output
    always_ff @(posedge CLK_SYS or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            IRQ <= 1'b0;
        end
        else
        begin
            IRQ <= |(int_status & int_mask);
        end
    end

    // Pin: comparator follows live state, interrupt mode latches
    always_ff @(posedge CLK_SYS or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            OVER_TEMP_O <= 1'b0;
            OVER_TEMP_OE <= 1'b0;
        end
        else
        begin
            OVER_TEMP_O <= 1'b0;
            if (!config_reg[CFG_OUT_EN])
            begin
                OVER_TEMP_OE <= 1'b0;
            end
            else if (config_reg[CFG_INT_MODE])
            begin
                OVER_TEMP_OE <= |int_status[NUM_CH-1:0];
            end
            else
            begin
                OVER_TEMP_OE <= |over;
            end
        end
    end

    // Read mux and address check
    always_comb
    begin
        next_rdata = '0;
        next_err = 1'b0;
        case (PADDR)
            OFS_CONFIG: next_rdata = {29'h0, config_reg};
            OFS_CHAN_EN: next_rdata = {28'h0, chan_en};
            OFS_STATUS: next_rdata = {20'h0, frozen, 3'h0, !seq_busy && config_reg[CFG_STANDBY],
                                      seq_busy, 1'b0, ADC_CHANNEL};
            OFS_BUS_ADDR: next_rdata = {25'h0, BUS_TARGET_ADDR};
            OFS_INT_STATUS: next_rdata = {27'h0, int_status};
            OFS_INT_MASK: next_rdata = {27'h0, int_mask};
            default:
            begin
                next_err = 1'b1;
                for (int c = 0; c < NUM_CH; c++)
                begin
                    if (PADDR == OFS_TEMP_HI + 8'(8 * c))
                    begin
                        next_rdata = {24'h0, temp[c][15:8]};
                        next_err = 1'b0;
                    end
                    if (PADDR == OFS_TEMP_LO + 8'(8 * c))
                    begin
                        next_rdata = {24'h0, lo_byte[c]};
                        next_err = 1'b0;
                    end
                    if (PADDR == OFS_THRESH + 8'(4 * c))
                    begin
                        next_rdata = {16'h0, thresh[c]};
                        next_err = 1'b0;
                    end
                end
            end
        endcase
    end

    // APB answer: one wait state, bus served in standby too
    always_ff @(posedge CLK_SYS or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            PREADY <= 1'b0;
            PRDATA <= '0;
            PSLVERR <= 1'b0;
        end
        else if (PSEL && PENABLE && !PREADY)
        begin
            PREADY <= 1'b1;
            PRDATA <= PWRITE ? 32'h0 : next_rdata;
            PSLVERR <= next_err;
        end
        else
        begin
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
        end
    end
endmodule : tcs_top
`default_nettype wire
